// >>> src/gcc_pkg.sv
package gcc_pkg;
  // Register byte offsets
  localparam logic [7:0] GCC_OFS_STATUS = 8'h00;
  localparam logic [7:0] GCC_OFS_IE_CLR = 8'h04;
  localparam logic [7:0] GCC_OFS_IE_SET = 8'h08;
  localparam logic [7:0] GCC_OFS_PRESC = 8'h0A;
  localparam logic [7:0] GCC_OFS_CH_CTRL = 8'h0C;
  localparam logic [7:0] GCC_OFS_CH_SEL = 8'h0E;
  localparam logic [7:0] GCC_OFS_LF_CTRL = 8'h10;
  // Reset values
  localparam logic [2:0] GCC_PRESC_RST = 3'h0;
  localparam logic [31:0] GCC_IE_RST = 32'h0000_0000;
  localparam logic [7:0] GCC_LF_RST = 8'h00;
  // Field positions
  localparam int GCC_STATUS_BUSY_BIT = 0;
  localparam int GCC_LF_EN_BIT = 3;
  localparam int GCC_CH_ID_LSB = 0;
  localparam int GCC_CH_GEN_LSB = 8;
  localparam int GCC_CH_EN_BIT = 14;
  localparam int GCC_CH_LOCK_BIT = 15;
  // Interrupt enable bit positions
  localparam int GCC_IE_CRYSTAL_OSCILLATOR_RDY = 0;
  localparam int GCC_IE_FLL_COARSE = 7;
  localparam int GCC_IE_FLL_REFSTOP = 8;
  localparam int GCC_IE_SUP_RDY = 9;
  localparam int GCC_IE_SUP_DET = 10;
  localparam int GCC_IE_SUP_SYNC = 11;
  localparam int GCC_IE_PLL_RISE = 15;
  localparam int GCC_IE_PLL_FALL = 16;
  // Implemented enables; bits 14:12 and other holes read zero
  localparam logic [31:0] GCC_IE_MASK = 32'h0001_8F81;
  // Channel identifiers
  localparam logic [5:0] GCC_ID_SLOW_SERIAL = 6'h13;
  localparam logic [5:0] GCC_ID_SERIAL0 = 6'h14;
  localparam logic [5:0] GCC_ID_LAST = 6'h22;
  localparam int GCC_NUM_CH = 35;
  // Power-reset channel values
  localparam logic [3:0] GCC_GEN_RST = 4'h0;
  localparam logic [3:0] GCC_WDT_GEN_RST = 4'h2;
  // Synchronizer states, Gray along the path
  typedef enum logic [1:0] {
    GCC_SY_IDLE = 2'b00,
    GCC_SY_CAPT = 2'b01,
    GCC_SY_XFER = 2'b11,
    GCC_SY_DONE = 2'b10
  } gcc_sync_t;
endpackage

// >>> src/gcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module gcc_top #(
  parameter logic [5:0] RTC_ID = 6'h04,
  parameter logic [5:0] WDT_ID = 6'h03
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic user_reset,
  input wire logic nvm_wdt_enable,
  input wire logic nvm_wdt_always_on,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic sync_in_progress_flag,
  input wire logic [31:0] osc_irq_flags,
  output logic osc_irq_req,
  output logic bus_b_clk_en,
  output logic [gcc_pkg::GCC_NUM_CH-1:0] channel_clock_enable,
  input wire logic lf_osc_in,
  output logic lf_osc_out
);
  import gcc_pkg::*;

  // Bus-domain registers
  logic [2:0] bus_b_divider_code_ff;
  logic [31:0] ie_ff;
  logic [7:0] lf_ctrl_ff;
  logic [5:0] ch_sel_ff;
  logic [31:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  // Core-domain channel storage
  logic [3:0] source_generator_field_ff [GCC_NUM_CH];
  logic [GCC_NUM_CH-1:0] channel_clock_enable_ff;
  logic [GCC_NUM_CH-1:0] channel_write_lock_ff;
  // Straps caught one cycle after power reset
  logic strap_pend_ff;
  logic wdt_en_strap_ff;
  logic wdt_lock_strap_ff;
  // Synchronizer
  gcc_sync_t sync_state_ff;
  gcc_sync_t nxt_sync_state;
  logic [15:0] sync_data_ff;
  logic sync_id_ok_ff; // Captured ID names a real channel
  // Divider
  logic [6:0] div_cnt_ff;
  logic [6:0] div_mask;
  logic bus_b_clk_en_ff;
  // Interrupt request
  logic osc_irq_req_ff;
  // Low-frequency path
  logic lf_sync1_ff;
  logic lf_sync2_ff;
  logic lf_osc_out_ff;

  // Decoded write strobes
  logic wr_ie_clr;
  logic wr_ie_set;
  logic wr_presc;
  logic wr_ch_ctrl;
  logic wr_ch_sel;
  logic wr_lf;
  logic [5:0] wr_id;
  logic wr_id_valid;
  logic commit;
  logic [5:0] cm_id;

  assign wr_ie_clr = reg_wr && (reg_addr == GCC_OFS_IE_CLR);
  assign wr_ie_set = reg_wr && (reg_addr == GCC_OFS_IE_SET);
  assign wr_presc = reg_wr && (reg_addr == GCC_OFS_PRESC);
  assign wr_ch_ctrl = reg_wr && (reg_addr == GCC_OFS_CH_CTRL);
  assign wr_ch_sel = reg_wr && (reg_addr == GCC_OFS_CH_SEL);
  assign wr_lf = reg_wr && (reg_addr == GCC_OFS_LF_CTRL);
  assign wr_id = reg_wdata[GCC_CH_ID_LSB +: 6];
  // Reserved IDs above the last peripheral are never stored in the channel array
  assign wr_id_valid = (wr_id <= GCC_ID_LAST);
  assign cm_id = sync_data_ff[GCC_CH_ID_LSB +: 6];
  // Commit only on the last synchronizer step, and only for a real channel
  assign commit = (sync_state_ff == GCC_SY_DONE) && sync_id_ok_ff;

  // Prescaler field; reserved bits are not stored at all
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_b_divider_code_ff <= GCC_PRESC_RST;
    end else if (wr_presc) begin
      bus_b_divider_code_ff <= reg_wdata[2:0];
    end
  end

  // Shared enable flops written by both views; set wins on a same-cycle conflict
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ie_ff <= GCC_IE_RST;
    end else if (wr_ie_set) begin
      ie_ff <= (ie_ff | reg_wdata) & GCC_IE_MASK;
    end else if (wr_ie_clr) begin
      ie_ff <= ie_ff & ~reg_wdata & GCC_IE_MASK;
    end
  end

  // Low-frequency control register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lf_ctrl_ff <= GCC_LF_RST;
    end else if (wr_lf) begin
      lf_ctrl_ff <= reg_wdata[7:0];
    end
  end

  // Channel readback selector lives in the bus domain
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ch_sel_ff <= 6'h00;
    end else if (wr_ch_sel) begin
      ch_sel_ff <= wr_id;
    end else if (wr_ch_ctrl && (sync_state_ff == GCC_SY_IDLE)) begin
      ch_sel_ff <= wr_id;
    end
  end

  // Synchronizer sequencing; writes arriving while busy are dropped
  always_comb begin
    nxt_sync_state = sync_state_ff;
    unique case (sync_state_ff)
      GCC_SY_IDLE: begin
        // Even with one common clock the transfer still takes the full path
        if (wr_ch_ctrl) begin
          nxt_sync_state = GCC_SY_CAPT;
        end
      end
      GCC_SY_CAPT: begin
        nxt_sync_state = GCC_SY_XFER;
      end
      GCC_SY_XFER: begin
        nxt_sync_state = GCC_SY_DONE;
      end
      GCC_SY_DONE: begin
        nxt_sync_state = GCC_SY_IDLE;
      end
    endcase
  end

  // State register of the shared synchronizer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_state_ff <= GCC_SY_IDLE;
    end else begin
      sync_state_ff <= nxt_sync_state;
    end
  end

  // Captured write word, held for the whole transfer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_data_ff <= 16'h0000;
    end else if (wr_ch_ctrl && (sync_state_ff == GCC_SY_IDLE)) begin
      sync_data_ff <= reg_wdata[15:0];
    end
  end

  // Reserved IDs still run the full handshake so busy timing stays uniform,
  // but this flag keeps them from ever reaching the channel array
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_id_ok_ff <= 1'b0;
    end else if (wr_ch_ctrl && (sync_state_ff == GCC_SY_IDLE)) begin
      sync_id_ok_ff <= wr_id_valid;
    end
  end

  // Busy flag, registered so it rises the cycle after the write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_in_progress_flag <= 1'b0;
    end else begin
      sync_in_progress_flag <= (nxt_sync_state != GCC_SY_IDLE);
    end
  end

  // Strap capture after power reset release; flops themselves reset to constants
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_pend_ff <= 1'b1;
      wdt_en_strap_ff <= 1'b0;
      wdt_lock_strap_ff <= 1'b0;
    end else if (strap_pend_ff) begin
      strap_pend_ff <= 1'b0;
      wdt_en_strap_ff <= nvm_wdt_enable;
      wdt_lock_strap_ff <= nvm_wdt_always_on;
    end
  end

  // Channel control array: power reset, user reset, strap load and commit
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < GCC_NUM_CH; i++) begin
      if (reset) begin
        // Every channel including the real-time counter
        source_generator_field_ff[i] <= (i == int'(WDT_ID)) ? GCC_WDT_GEN_RST : GCC_GEN_RST;
        channel_clock_enable_ff[i] <= 1'b0;
        channel_write_lock_ff[i] <= 1'b0;
      end else if (strap_pend_ff && (i == int'(WDT_ID))) begin
        channel_clock_enable_ff[i] <= nvm_wdt_enable;
        channel_write_lock_ff[i] <= nvm_wdt_always_on;
      end else if (user_reset) begin
        // Locked channels and the real-time counter keep their contents
        if (!channel_write_lock_ff[i] && (i != int'(RTC_ID))) begin
          if (i == int'(WDT_ID)) begin
            source_generator_field_ff[i] <= GCC_WDT_GEN_RST;
            channel_clock_enable_ff[i] <= wdt_en_strap_ff;
            channel_write_lock_ff[i] <= wdt_lock_strap_ff;
          end else begin
            source_generator_field_ff[i] <= GCC_GEN_RST;
            channel_clock_enable_ff[i] <= 1'b0;
            channel_write_lock_ff[i] <= 1'b0;
          end
        end
      end else if (commit && (cm_id == 6'(i)) && !channel_write_lock_ff[i]) begin
        // A set lock bit makes the channel read-only until power reset
        source_generator_field_ff[i] <= sync_data_ff[GCC_CH_GEN_LSB +: 4];
        channel_clock_enable_ff[i] <= sync_data_ff[GCC_CH_EN_BIT];
        channel_write_lock_ff[i] <= sync_data_ff[GCC_CH_LOCK_BIT];
      end
    end
  end

  // Channel enables out, one flop stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      channel_clock_enable <= '0;
    end else begin
      channel_clock_enable <= channel_clock_enable_ff;
    end
  end

  // Divider mask: low code bits of the free-running counter
  always_comb begin
    div_mask = 7'h00;
    for (int b = 0; b < 7; b++) begin
      if (b < int'(bus_b_divider_code_ff)) begin
        div_mask[b] = 1'b1;
      end
    end
  end

  // Free-running counter; trades exact phase on a code change for simplicity
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_cnt_ff <= 7'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 7'h01;
    end
  end

  // One-cycle enable every 2^code cycles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_b_clk_en_ff <= 1'b0;
    end else begin
      bus_b_clk_en_ff <= ((div_cnt_ff & div_mask) == 7'h00);
    end
  end

  // Request raised while any enabled flag stands
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      osc_irq_req_ff <= 1'b0;
    end else begin
      osc_irq_req_ff <= |(osc_irq_flags & ie_ff);
    end
  end

  // Oscillator pin crosses two flops before gating
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lf_sync1_ff <= 1'b0;
      lf_sync2_ff <= 1'b0;
    end else begin
      lf_sync1_ff <= lf_osc_in;
      lf_sync2_ff <= lf_sync1_ff;
    end
  end

  // Output held low unless enabled
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lf_osc_out_ff <= 1'b0;
    end else begin
      lf_osc_out_ff <= lf_sync2_ff & lf_ctrl_ff[GCC_LF_EN_BIT];
    end
  end

  // Read mux, answered the next cycle; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_ff <= 32'h0000_0000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          GCC_OFS_STATUS: begin
            reg_rdata_ff <= {31'h0, sync_in_progress_flag};
          end
          GCC_OFS_IE_CLR, GCC_OFS_IE_SET: begin
            reg_rdata_ff <= ie_ff;
          end
          GCC_OFS_PRESC: begin
            reg_rdata_ff <= {29'h0, bus_b_divider_code_ff};
          end
          GCC_OFS_CH_CTRL: begin
            if (ch_sel_ff <= GCC_ID_LAST) begin
              reg_rdata_ff <= {16'h0, channel_write_lock_ff[ch_sel_ff],
                channel_clock_enable_ff[ch_sel_ff], 2'b00,
                source_generator_field_ff[ch_sel_ff], 2'b00, ch_sel_ff};
            end else begin
              reg_rdata_ff <= {26'h0, ch_sel_ff};
            end
          end
          GCC_OFS_CH_SEL: begin
            reg_rdata_ff <= {26'h0, ch_sel_ff};
          end
          GCC_OFS_LF_CTRL: begin
            reg_rdata_ff <= {24'h0, lf_ctrl_ff};
          end
          default: begin
            reg_rdata_ff <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign bus_b_clk_en = bus_b_clk_en_ff;
  assign osc_irq_req = osc_irq_req_ff;
  assign lf_osc_out = lf_osc_out_ff;
endmodule
`default_nettype wire

// >>> test/gcc_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the clock-control block
module gcc_props import gcc_pkg::*; #(
  parameter logic [5:0] WDT_ID = 6'h03
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sync_in_progress_flag,
  input wire logic [31:0] osc_irq_flags,
  input wire logic osc_irq_req,
  input wire logic bus_b_clk_en,
  input wire logic [GCC_NUM_CH-1:0] channel_clock_enable,
  input wire logic lf_osc_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Write strobes decoded per register
  wire chw = reg_wr && reg_addr == GCC_OFS_CH_CTRL;
  wire lfw = reg_wr && reg_addr == GCC_OFS_LF_CTRL;
  wire pw = reg_wr && reg_addr == GCC_OFS_PRESC;
  // Three busy cycles, then free
  sequence sync_run;
    sync_in_progress_flag [*3] ##1 !sync_in_progress_flag;
  endsequence
  // Output disabled, no rewrite right after
  sequence lf_off;
    lfw && !reg_wdata[3] ##1 !lfw;
  endsequence
  sequence div_one;
    pw && reg_wdata[2:0] == 3'h0 ##1 !pw;
  endsequence
  a_sync_busy_len: assert property (chw && !sync_in_progress_flag |=> sync_run)
    else $error("busy not three cycles");
  a_one_xfer: assert property (sync_in_progress_flag [*3] |=> !sync_in_progress_flag)
    else $error("busy stretched");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_spur_valid: assert property (!reg_rd |=> !reg_rvalid)
    else $error("spurious valid");
  a_presc_rsvd_zero: assert property (reg_rd && reg_addr == GCC_OFS_PRESC
    |=> reg_rdata[31:3] == '0)
    else $error("prescaler reserved bits set");
  a_ie_rsvd_zero: assert property (reg_rd && (reg_addr == GCC_OFS_IE_CLR ||
    reg_addr == GCC_OFS_IE_SET) |=> (reg_rdata & ~GCC_IE_MASK) == '0)
    else $error("enable reserved bits set");
  a_irq_quiet: assert property (osc_irq_flags == '0 |=> !osc_irq_req)
    else $error("request without flag");
  a_lf_gate: assert property (lf_off |-> ##1 !lf_osc_out)
    else $error("low freq output not gated");
  a_div_one: assert property (div_one |-> ##1 bus_b_clk_en [*3])
    else $error("divide by one not steady");
  a_chan_power_rst: assert property ($fell(reset) |->
    ##2 (channel_clock_enable & ~(GCC_NUM_CH'(1) << WDT_ID)) == '0)
    else $error("channel enable after power reset");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import gcc_pkg::*;
  // Inputs, all valued at time zero
  logic sys_clk = 0, reset = 1, user_reset = 0, reg_wr = 0, reg_rd = 0, lf_osc_in = 0;
  logic nvm_wdt_enable = 1, nvm_wdt_always_on = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, osc_irq_flags = 0, rnd = 32'h228c, ex;
  logic [31:0] reg_rdata;
  logic reg_rvalid, sync_in_progress_flag, osc_irq_req, bus_b_clk_en, lf_osc_out;
  logic [GCC_NUM_CH-1:0] channel_clock_enable;
  logic [31:0] expq[$]; // Expected read data, oldest first
  int n_fail = 0, samples_checked = 0;
  int ie_bits[8] = '{0, 7, 8, 9, 10, 11, 15, 16};
  gcc_top dut_u (.sys_clk, .reset, .user_reset, .nvm_wdt_enable, .nvm_wdt_always_on,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .sync_in_progress_flag, .osc_irq_flags, .osc_irq_req, .bus_b_clk_en,
    .channel_clock_enable, .lf_osc_in, .lf_osc_out);
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  // Inputs move 1 ns after the edge, away from sampling
  task automatic cyc(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
  endtask
  // Channel write, then bounded wait for the synchronizer
  task automatic chw(logic [31:0] d);
    int k = 0;
    wr(GCC_OFS_CH_CTRL, d);
    `CHK(sync_in_progress_flag, 1'b1)
    while (sync_in_progress_flag !== 1'b0 && k < 10) begin
      cyc(1);
      k++;
    end
    `CHK(sync_in_progress_flag, 1'b0)
    cyc(2);
  endtask
  task automatic preset(logic en, logic ao);
    nvm_wdt_enable = en;
    nvm_wdt_always_on = ao;
    reset = 1;
    cyc(2);
    reset = 0;
    cyc(4);
  endtask
  task automatic conclude();
    // A read that was never answered counts as a mismatch too
    if (expq.size() != 0) begin
      n_fail++;
    end
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Read answers are matched against the oldest expectation
  always @(negedge sys_clk) if (reg_rvalid === 1'b1) begin
    ex = expq.pop_front();
    `CHK(reg_rdata, ex)
  end
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
  initial begin
    int c;
    logic [31:0] a, b, m;
    cyc(16);
    reset = 0;
    cyc(2);
    // Every divider code: pulses in 256 cycles
    for (int i = 0; i < 8; i++) begin
      wr(GCC_OFS_PRESC, {29'h0, 3'(i)});
      rd(GCC_OFS_PRESC, {29'h0, 3'(i)});
      c = 0;
      repeat (256) begin
        cyc(1);
        c += (bus_b_clk_en === 1'b1);
      end
      `CHK(c, 256 >> i)
    end
    // Set and clear views on one set of enables
    a = xs();
    b = xs();
    wr(GCC_OFS_IE_SET, a);
    rd(GCC_OFS_IE_CLR, a & GCC_IE_MASK);
    wr(GCC_OFS_IE_CLR, b);
    rd(GCC_OFS_IE_SET, a & ~b & GCC_IE_MASK);
    wr(GCC_OFS_IE_CLR, 32'hFFFF_FFFF);
    foreach (ie_bits[j]) begin
      m = 32'h1 << ie_bits[j];
      osc_irq_flags = m;
      cyc(2);
      `CHK(osc_irq_req, 1'b0)
      wr(GCC_OFS_IE_SET, m);
      cyc(1);
      `CHK(osc_irq_req, 1'b1)
      osc_irq_flags = ~m;
      cyc(2);
      `CHK(osc_irq_req, 1'b0)
      wr(GCC_OFS_IE_CLR, m);
      osc_irq_flags = '0;
    end
    // Low frequency output gate
    lf_osc_in = 1;
    wr(GCC_OFS_LF_CTRL, 32'h8);
    rd(GCC_OFS_LF_CTRL, 32'h0000_0008);
    cyc(4);
    `CHK(lf_osc_out, 1'b1)
    wr(GCC_OFS_LF_CTRL, 32'h0);
    cyc(4);
    `CHK(lf_osc_out, 1'b0)
    // Channels: plain, locked, counter, busy drop
    chw(32'h0000_4314);
    rd(GCC_OFS_CH_CTRL, 32'h0000_4314);
    chw(32'h0000_C115);
    chw(32'h0000_4004);
    chw(32'h0000_0015);
    rd(GCC_OFS_CH_CTRL, 32'h0000_C115);
    wr(GCC_OFS_CH_CTRL, 32'h0000_4316);
    rd(GCC_OFS_STATUS, 32'h0000_0001);
    chw(32'h0000_4317);
    `CHK(channel_clock_enable[23:20], 4'b0111)
    chw(32'h0000_4323);
    rd(GCC_OFS_CH_CTRL, 32'h0000_0023);
    user_reset = 1;
    cyc(1);
    user_reset = 0;
    cyc(3);
    `CHK({channel_clock_enable[22:20], channel_clock_enable[4:3]}, 5'b01011)
    // Power reset with both strap settings
    preset(1, 0);
    `CHK(channel_clock_enable, GCC_NUM_CH'(1) << 3)
    rd(GCC_OFS_PRESC, 32'h0);
    wr(GCC_OFS_CH_SEL, 32'h3);
    rd(GCC_OFS_CH_CTRL, 32'h0000_4203);
    preset(0, 1);
    wr(GCC_OFS_CH_SEL, 32'h3);
    rd(GCC_OFS_CH_CTRL, 32'h0000_8203);
    cyc(4);
    conclude();
  end
endmodule
bind gcc_top gcc_props #(.WDT_ID(WDT_ID)) chk_u (.sys_clk, .reset, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .sync_in_progress_flag, .osc_irq_flags,
  .osc_irq_req, .bus_b_clk_en, .channel_clock_enable, .lf_osc_out);
`default_nettype wire
